// ### hw/fbm_cycle.sv
// single read or write cycle on the flash pins
module fbm_cycle
    import fbm_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic word_mode, // 1 word, 0 byte
    fbm_cycle_if.eng cy, // cycle request
    output logic sel_n, // flash chip select
    output logic oe_n, // flash output enable
    output logic we_n, // flash write enable
    output logic [19:0] addr_pin, // flash address
    output logic [15:0] dq_out, // data to flash
    output logic [15:0] dq_oe, // data drive enables
    input wire logic [15:0] dq_in // data from flash
);
    fbm_cycle_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [15:0] rdata, next_rdata;
    logic wr, next_wr;
    logic [20:0] addr, next_addr;
    logic [15:0] wd, next_wd;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_rdata = rdata;
        next_wr = wr;
        next_addr = addr;
        next_wd = wd;
        case (state)
            FBM_CY_IDLE: begin
                if (cy.start) begin
                    next_wr = cy.write;
                    next_addr = cy.addr;
                    next_wd = cy.wdata;
                    next_cnt = CNT_W'(SETUP_CYC);
                    next_state = FBM_CY_SETUP;
                end
            end
            FBM_CY_SETUP: begin
                if (cnt <= 1) begin
                    // full select access time on reads
                    next_cnt = wr ? CNT_W'(WPULSE_CYC) : CNT_W'(ACCESS_CYC);
                    next_state = FBM_CY_STROBE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            FBM_CY_STROBE: begin
                if (cnt <= 1) begin
                    if (!wr) begin
                        next_rdata = word_mode ? dq_in : {8'h00, dq_in[7:0]};
                    end
                    next_state = FBM_CY_HOLD;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: next_state = FBM_CY_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FBM_CY_IDLE;
            cnt <= '0;
            rdata <= '0;
            wr <= 1'b0;
            addr <= '0;
            wd <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            rdata <= next_rdata;
            wr <= next_wr;
            addr <= next_addr;
            wd <= next_wd;
        end
    end

    assign cy.done = (state == FBM_CY_HOLD);
    assign cy.rdata = rdata;
    // high between cycles gives standby
    assign sel_n = (state == FBM_CY_IDLE);
    assign oe_n = !((state == FBM_CY_STROBE) && !wr);
    assign we_n = !((state == FBM_CY_STROBE) && wr);
    // in byte mode addr[0] goes out on line 15
    assign addr_pin = word_mode ? addr[19:0] : addr[20:1];
    always_comb begin
        dq_out = word_mode ? wd : {addr[0], 7'h00, wd[7:0]};
        dq_oe = 16'h0000;
        if (state != FBM_CY_IDLE) begin
            dq_oe = wr ? (word_mode ? 16'hFFFF : 16'h80FF) : {!word_mode, 15'h0000};
        end
    end
endmodule

// ### hw/fbm_cycle_if.sv
// interface between sequencer and single bus-cycle engine
interface fbm_cycle_if;
    logic start;
    logic write;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport seq (output start, output write, output addr, output wdata,
                 input done, input rdata);
    modport eng (input start, input write, input addr, input wdata,
                 output done, output rdata);
endinterface

// ### hw/fbm_host.sv
// host controller sequencing command writes, reads and reset on the flash
module fbm_host
    import fbm_pkg::*;
#(
    parameter int unsigned READY_OP_CYCLES = READY_OP_CYC // long recovery count
)
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic req_valid, // request strobe
    output logic req_ready, // request taken
    input wire logic [2:0] req_op, // request kind
    input wire logic [20:0] req_addr, // word or byte address
    input wire logic [15:0] req_wdata, // program data
    input wire logic req_last, // last sector of erase
    input wire logic word_mode, // 1 word
    input wire logic hw_reset_req, // reset the flash
    output logic rsp_valid, // request done
    output logic [15:0] rsp_rdata, // read data or status
    output logic [5:0] rsp_sector, // sector of address
    output logic op_aborted, // last op cut by reset
    output logic bypass_active, // bypass mode
    output logic ident_active, // identify mode
    output logic dev_busy, // flash busy
    output logic sel_n, // flash chip select
    output logic oe_n, // flash output enable
    output logic we_n, // flash write enable
    output logic reset_n_pin, // flash reset pin
    output logic width_sel, // flash width select, 1 word
    output logic [19:0] addr_pin, // flash address
    output logic [15:0] dq_out, // data to flash
    output logic [15:0] dq_oe, // data drive enables
    input wire logic [15:0] dq_in, // data from flash
    input wire logic completion_flag // flash ready
);
    typedef enum logic [2:0] {
        FBM_IDLE = 3'b000,
        FBM_ISSUE = 3'b001,
        FBM_WAIT = 3'b011,
        FBM_RESP = 3'b010,
        FBM_RST = 3'b110,
        FBM_RECOV = 3'b111
    } fbm_state_e;

    fbm_cycle_if cy();
    fbm_state_e state, next_state;
    logic [2:0] step, next_step;
    logic [2:0] nsteps, next_nsteps;
    fbm_op_e op, next_op;
    logic [20:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [15:0] rd, next_rd;
    logic bypass, next_bypass;
    logic ident, next_ident;
    logic aborted, next_aborted;
    logic was_busy, next_was_busy;
    logic [5:0] sector, next_sector;
    logic cy_write;
    logic [20:0] cy_addr;
    logic [15:0] cy_wdata;

    fbm_cycle u_cycle (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .word_mode(word_mode),
        .cy(cy.eng),
        .sel_n(sel_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr_pin(addr_pin),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in)
    );

    // number of bus cycles each request takes
    function automatic logic [2:0] steps_of(input fbm_op_e o, input logic byp, input logic lst);
        case (o)
            FBM_OP_READ: steps_of = 3'd1;
            FBM_OP_PROGRAM: steps_of = byp ? 3'd2 : 3'd4;
            FBM_OP_SECTOR_ERASE, FBM_OP_CHIP_ERASE: steps_of = 3'd6;
            FBM_OP_IDENTIFY, FBM_OP_BYPASS_ENTER: steps_of = 3'd3;
            FBM_OP_BYPASS_EXIT: steps_of = 3'd2;
            default: steps_of = 3'd1;
        endcase
    endfunction

    // unlock address in the current width
    function automatic logic [20:0] cmd_addr(input logic [11:0] a, input logic wm);
        cmd_addr = wm ? {9'h000, a} : {8'h00, a, 1'b0};
    endfunction

    // address and data of bus cycle number s
    always_comb begin
        cy_write = (op != FBM_OP_READ);
        cy_addr = cmd_addr(UNLOCK_ADDR1, word_mode);
        cy_wdata = {8'h00, UNLOCK_DATA1};
        if (op == FBM_OP_READ) begin
            cy_addr = addr;
        end else if (op == FBM_OP_ARRAY_MODE) begin
            cy_wdata = {8'h00, CMD_RESET};
        end else if (op == FBM_OP_BYPASS_EXIT) begin
            cy_wdata = {8'h00, (step == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2};
        end else if (op == FBM_OP_PROGRAM && bypass) begin
            cy_wdata = (step == 3'd0) ? {8'h00, CMD_PROGRAM} : wdata;
            cy_addr = (step == 3'd0) ? cy_addr : addr;
        end else if (step == 3'd1 || step == 3'd4) begin
            cy_addr = cmd_addr(UNLOCK_ADDR2, word_mode);
            cy_wdata = {8'h00, UNLOCK_DATA2};
        end else if (step == 3'd2) begin
            case (op)
                FBM_OP_PROGRAM: cy_wdata = {8'h00, CMD_PROGRAM};
                FBM_OP_IDENTIFY: cy_wdata = {8'h00, CMD_IDENTIFY};
                FBM_OP_BYPASS_ENTER: cy_wdata = {8'h00, CMD_BYPASS_ENTER};
                default: cy_wdata = {8'h00, CMD_ERASE_SETUP};
            endcase
        end else if (step == 3'd3 && op == FBM_OP_PROGRAM) begin
            cy_addr = addr;
            cy_wdata = wdata;
        end else if (step == 3'd5) begin
            cy_addr = (op == FBM_OP_CHIP_ERASE) ? cy_addr : addr;
            cy_wdata = {8'h00, (op == FBM_OP_CHIP_ERASE) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE};
        end
    end

    assign cy.start = (state == FBM_ISSUE);
    assign cy.write = cy_write;
    assign cy.addr = cy_addr;
    assign cy.wdata = cy_wdata;

    always_comb begin
        next_state = state;
        next_step = step;
        next_nsteps = nsteps;
        next_op = op;
        next_addr = addr;
        next_wdata = wdata;
        next_cnt = cnt;
        next_rd = rd;
        next_bypass = bypass;
        next_ident = ident;
        next_aborted = aborted;
        next_was_busy = was_busy;
        next_sector = sector;
        case (state)
            FBM_IDLE: begin
                if (hw_reset_req) begin
                    next_was_busy = !completion_flag;
                    next_aborted = !completion_flag;
                    next_cnt = CNT_W'(RESET_PULSE_CYC);
                    next_state = FBM_RST;
                end else if (req_valid) begin
                    next_op = fbm_op_e'(req_op);
                    next_addr = req_addr;
                    next_wdata = req_wdata;
                    next_sector = fbm_sector_of(word_mode ? req_addr[19:0] : req_addr[20:1]);
                    next_nsteps = steps_of(fbm_op_e'(req_op), bypass, req_last);
                    next_step = 3'd0;
                    next_state = FBM_ISSUE;
                end
            end
            FBM_ISSUE: next_state = FBM_WAIT;
            FBM_WAIT: begin
                if (cy.done) begin
                    if (step + 3'd1 >= nsteps) begin
                        next_rd = cy.rdata;
                        next_state = FBM_RESP;
                    end else begin
                        next_step = step + 3'd1;
                        next_state = FBM_ISSUE;
                    end
                end
            end
            FBM_RESP: begin
                case (op)
                    FBM_OP_IDENTIFY: next_ident = 1'b1;
                    FBM_OP_BYPASS_ENTER: next_bypass = 1'b1;
                    FBM_OP_BYPASS_EXIT: next_bypass = 1'b0;
                    FBM_OP_ARRAY_MODE: next_ident = 1'b0;
                    default: ;
                endcase
                next_aborted = aborted && (op == FBM_OP_READ);
                next_state = FBM_IDLE;
            end
            FBM_RST: begin
                if (cnt <= 1) begin
                    next_cnt = was_busy ? CNT_W'(READY_OP_CYCLES) : CNT_W'(READY_IDLE_CYC);
                    next_state = FBM_RECOV;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_bypass = 1'b0;
                next_ident = 1'b0;
                if (cnt <= 1 && completion_flag) begin
                    next_state = FBM_IDLE;
                end else if (cnt > 1) begin
                    next_cnt = cnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FBM_IDLE;
            step <= '0;
            nsteps <= 3'd1;
            op <= FBM_OP_READ;
            addr <= '0;
            wdata <= '0;
            cnt <= '0;
            rd <= '0;
            bypass <= 1'b0;
            ident <= 1'b0;
            aborted <= 1'b0;
            was_busy <= 1'b0;
            sector <= '0;
        end else begin
            state <= next_state;
            step <= next_step;
            nsteps <= next_nsteps;
            op <= next_op;
            addr <= next_addr;
            wdata <= next_wdata;
            cnt <= next_cnt;
            rd <= next_rd;
            bypass <= next_bypass;
            ident <= next_ident;
            aborted <= next_aborted;
            was_busy <= next_was_busy;
            sector <= next_sector;
        end
    end

    assign req_ready = (state == FBM_IDLE) && !hw_reset_req;
    assign rsp_valid = (state == FBM_RESP);
    assign rsp_rdata = rd;
    assign rsp_sector = sector;
    assign op_aborted = aborted;
    assign bypass_active = bypass;
    assign ident_active = ident;
    assign dev_busy = !completion_flag;
    assign reset_n_pin = rst_n && (state != FBM_RST);
    assign width_sel = word_mode;
endmodule

// ### hw/fbm_pkg.sv
// package of constants and types for the flash bus mode host controller
package fbm_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // bus timing in ns
    localparam int unsigned T_ACCESS_NS = 70;
    localparam int unsigned T_SETUP_NS = 30;
    localparam int unsigned T_WPULSE_NS = 35;
    localparam int unsigned T_RESET_PULSE_NS = 500;
    localparam int unsigned T_SLEEP_EXTRA_NS = 30;
    localparam int unsigned T_READY_IDLE_NS = 500;
    localparam int unsigned T_READY_OP_NS = 20000;
    // least times round up
    localparam int unsigned ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WPULSE_CYC = (T_WPULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RESET_PULSE_CYC = (T_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SLEEP_CYC =
        ((T_ACCESS_NS + T_SLEEP_EXTRA_NS) * CLK_MHZ + 999) / 1000;
    localparam int unsigned READY_IDLE_CYC = (T_READY_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned READY_OP_CYC = (T_READY_OP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W = 16;
    // command unlock cycles
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h0_555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'h0_2AA;
    localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_IDENTIFY = 8'h90;
    localparam logic [7:0] CMD_BYPASS_ENTER = 8'h20;
    localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
    localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam int unsigned SECTOR_COUNT = 35;
    localparam logic [5:0] SECTOR_TOP_BASE = 6'h1F;

    // host requests
    typedef enum logic [2:0] {
        FBM_OP_READ = 3'h0,
        FBM_OP_PROGRAM = 3'h1,
        FBM_OP_SECTOR_ERASE = 3'h2,
        FBM_OP_CHIP_ERASE = 3'h3,
        FBM_OP_IDENTIFY = 3'h4,
        FBM_OP_BYPASS_ENTER = 3'h5,
        FBM_OP_BYPASS_EXIT = 3'h6,
        FBM_OP_ARRAY_MODE = 3'h7
    } fbm_op_e;

    // bus cycle engine states, gray coded along idle-setup-strobe-hold
    typedef enum logic [1:0] {
        FBM_CY_IDLE = 2'b00,
        FBM_CY_SETUP = 2'b01,
        FBM_CY_STROBE = 2'b11,
        FBM_CY_HOLD = 2'b10
    } fbm_cycle_e;

    // top-boot sector index from word address bits 19..12
    function automatic logic [5:0] fbm_sector_of(input logic [19:0] waddr);
        logic [5:0] s;
        s = {1'b0, waddr[19:15]};
        if (waddr[19:15] == 5'h1F) begin
            if (!waddr[14]) begin
                s = SECTOR_TOP_BASE;
            end else if (waddr[13]) begin
                s = SECTOR_TOP_BASE + 6'h03;
            end else begin
                s = SECTOR_TOP_BASE + 6'h01 + {5'h00, waddr[12]};
            end
        end
        return s;
    endfunction
endpackage

// ### sim/fbm_flash_model.sv
// behavioural model of the flash device on the parallel bus
module fbm_flash_model
    import fbm_pkg::*;
#(
    parameter int LAT = 6, // cycles to valid read data
    parameter logic [15:0] STATUS_WORD = 16'h0044, // read value while busy
    parameter logic [7:0] ID_CODE = 8'h5C // arbitrary identification value
)
(
    input wire logic core_clk, // clock
    input wire logic sel_n, // chip select
    input wire logic oe_n, // output enable
    input wire logic we_n, // write enable
    input wire logic reset_n_pin, // reset pin
    input wire logic width_sel, // 1 word
    input wire logic [19:0] addr_pin, // address
    input wire logic [15:0] dq_pins, // resolved data lines
    output logic [15:0] dev_dq, // data driven
    output logic [15:0] dev_oe, // drive enables
    output logic completion_flag // ready high
);
    logic [15:0] mem [logic [21:0]];
    logic [21:0] key;
    logic [19:0] aq;
    logic [15:0] rd;
    logic [7:0] d;
    int busy = 0, acc = 0, step = 0;
    bit prog, ident, byp, ers, bx;
    function automatic int ks(input logic [21:0] k);
        logic [19:0] a;
        a = k[21] ? k[19:0] : k[20:1];
        if (a[19:15] != 5'h1F) return int'(a[19:15]);
        return a[14] ? (a[13] ? 34 : 32 + int'(a[12])) : 31;
    endfunction
    assign key = width_sel ? {2'b10, addr_pin} : {1'b0, addr_pin, dq_pins[15]};
    assign completion_flag = (busy == 0);
    assign dev_oe = (!sel_n && !oe_n && reset_n_pin) ?
        (width_sel ? 16'hFFFF : 16'h00FF) : 16'h0000;
    assign dev_dq = (acc >= LAT) ? rd : ~rd;
    always @(negedge core_clk) begin
        if (!reset_n_pin) begin
            {prog, ident, byp, ers, bx} = 5'h00;
            step = 0;
            if (busy != 0) busy = 30;
        end else if (busy != 0) busy = busy - 1;
        rd = busy != 0 ? STATUS_WORD : ident ? {8'h00, ID_CODE} :
            mem.exists(key) ? mem[key] : 16'hFFFF;
        acc = (sel_n || oe_n || addr_pin != aq) ? 0 : acc + 1;
        aq = addr_pin;
    end
    always @(posedge we_n) if (!sel_n && oe_n && reset_n_pin && busy == 0) begin
        d = dq_pins[7:0];
        if (prog) begin
            mem[key] = width_sel ? dq_pins : {8'h00, d};
            prog = 0;
            busy = 40;
        end else if (byp) begin
            prog = (d == CMD_PROGRAM);
            if (bx && d == CMD_BYPASS_EXIT2) byp = 0;
            bx = (d == CMD_BYPASS_EXIT1);
        end else if (d == CMD_RESET) {step, ident, ers} = 0;
        else if (step < 2) step = (d == (step == 0 ? UNLOCK_DATA1 : UNLOCK_DATA2)) ? step + 1 : 0;
        else if (ers && (d == CMD_SECTOR_ERASE || d == CMD_CHIP_ERASE)) begin
            foreach (mem[k]) if (d == CMD_CHIP_ERASE || ks(k) == ks(key)) mem[k] = 16'hFFFF;
            {step, ers} = 0;
            busy = 60;
        end else begin
            step = 0;
            ers = (d == CMD_ERASE_SETUP);
            prog = (d == CMD_PROGRAM);
            ident = ident || (d == CMD_IDENTIFY);
            byp = (d == CMD_BYPASS_ENTER);
        end
    end
endmodule

// ### sim/fbm_host_assertions.sv
// pin-level checker for the flash bus mode host controller
module fbm_host_assertions
    import fbm_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst_n, // async reset
    input wire logic req_ready, // request accepted
    input wire logic sel_n, // chip select
    input wire logic oe_n, // output enable
    input wire logic we_n, // write enable
    input wire logic reset_n_pin, // flash reset
    input wire logic width_sel, // 1 word
    input wire logic [15:0] dq_oe, // data drive enables
    input wire logic completion_flag, // flash ready
    input wire logic dev_busy // busy level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_cnt;
    // saturated out of reset: no false short pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 8'hFF;
        else if (reset_n_pin) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    sequence s_write_strobe;
        !we_n [*4] ##1 we_n;
    endsequence
    sequence s_read_strobe;
        !oe_n [*7];
    endsequence
    property p_write_levels; !we_n |-> !sel_n && oe_n && reset_n_pin; endproperty
    property p_write_pulse; $fell(we_n) |-> s_write_strobe; endproperty
    property p_write_drive;
        !we_n |-> dq_oe == (width_sel ? 16'hFFFF : 16'h80FF);
    endproperty
    property p_read_levels; !oe_n |-> !sel_n && we_n && reset_n_pin; endproperty
    property p_read_release;
        !oe_n |-> dq_oe == (width_sel ? 16'h0000 : 16'h8000);
    endproperty
    property p_read_access; $fell(oe_n) |-> s_read_strobe; endproperty
    property p_select_first; $fell(oe_n) || $fell(we_n) |-> $past(sel_n, 2) == 1'b0; endproperty
    property p_reset_pulse; $rose(reset_n_pin) |-> low_cnt >= RESET_PULSE_CYC; endproperty
    property p_reset_quiet; !reset_n_pin |-> !req_ready && sel_n; endproperty
    property p_recovery; $rose(reset_n_pin) && $past(rst_n) |-> !req_ready [*8]; endproperty
    property p_busy_mirror; dev_busy == !completion_flag; endproperty
    a_write_levels:
        assert property (p_write_levels) else $error("write strobe without select");
    a_write_pulse:
        assert property (p_write_pulse) else $error("write pulse length wrong");
    a_write_drive:
        assert property (p_write_drive) else $error("write data lanes wrong");
    a_read_levels:
        assert property (p_read_levels) else $error("read strobe levels wrong");
    a_read_release:
        assert property (p_read_release) else $error("host drives data while reading");
    a_read_access:
        assert property (p_read_access) else $error("read strobe shorter than access");
    a_select_first:
        assert property (p_select_first) else $error("strobe before select setup");
    a_reset_pulse:
        assert property (p_reset_pulse) else $error("reset pulse too short");
    a_reset_quiet:
        assert property (p_reset_quiet) else $error("bus active during reset pulse");
    a_recovery:
        assert property (p_recovery) else $error("request taken right after reset");
    a_busy_mirror:
        assert property (p_busy_mirror) else $error("busy level not tracking flag");
endmodule
bind fbm_host fbm_host_assertions chk_u (.core_clk, .rst_n, .req_ready, .sel_n, .oe_n,
    .we_n, .reset_n_pin, .width_sel, .dq_oe, .completion_flag, .dev_busy);

// ### sim/tb_fbm_host.sv
// self-checking bench for the flash bus mode host controller
module tb_fbm_host
    import fbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] BUSY_STATUS = 16'h0044;
    localparam logic [7:0] ID_CODE = 8'h5C; // arbitrary identification value
    logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, word_mode = 1'b1;
    logic hw_reset_req = 1'b0, tick = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [20:0] req_addr = 21'h00_0000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready, rsp_valid, op_aborted, bypass_active, ident_active, dev_busy;
    logic sel_n, oe_n, we_n, reset_n_pin, width_sel, completion_flag;
    logic [15:0] rsp_rdata, dq_out, dq_oe, dq_in, dev_dq, dev_oe, rd;
    logic [5:0] rsp_sector, sec;
    logic [19:0] addr_pin;
    int num_errors = 0, checks_done = 0, wr_cnt = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) tick <= ~tick;
    always @(negedge we_n) wr_cnt++;
    // undriven lines toggle
    assign dq_in = (dq_oe & dq_out) | (dev_oe & dev_dq) | (~dq_oe & ~dev_oe & {16{tick}});
    fbm_host #(.READY_OP_CYCLES(20)) dut_u (.core_clk, .rst_n, .req_valid, .req_ready,
        .req_op, .req_addr, .req_wdata, .req_last(1'b0), .word_mode, .hw_reset_req,
        .rsp_valid, .rsp_rdata, .rsp_sector, .op_aborted, .bypass_active, .ident_active,
        .dev_busy, .sel_n, .oe_n, .we_n, .reset_n_pin, .width_sel, .addr_pin, .dq_out,
        .dq_oe, .dq_in, .completion_flag);
    fbm_flash_model #(.STATUS_WORD(BUSY_STATUS), .ID_CODE(ID_CODE)) flash_u (.core_clk,
        .sel_n, .oe_n, .we_n, .reset_n_pin, .width_sel, .addr_pin, .dq_pins(dq_in), .dev_dq,
        .dev_oe, .completion_flag);
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        chk(w, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic req(input fbm_op_e op, input logic [20:0] a, input logic [15:0] wd);
        int n = 0;
        {req_op, req_addr, req_wdata, req_valid} = {op, a, wd, 1'b1};
        while (req_ready !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            #1 n++;
        end
        {rd, sec} = {rsp_rdata, rsp_sector};
        chk1("response", 1'b1, rsp_valid);
        @(posedge core_clk);
        #1;
    endtask
    task automatic settle(input bit pulse_reset);
        int n = 0;
        hw_reset_req = pulse_reset;
        @(posedge core_clk);
        #1 hw_reset_req = 1'b0;
        while ((dev_busy !== 1'b0 || req_ready !== 1'b1) && n < 5000) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    task automatic t_sectors();
        logic [19:0] a [7] = '{20'h0_0000, 20'h0_8000, 20'hF_0000, 20'hF_8000, 20'hF_C000,
            20'hF_D000, 20'hF_E000};
        logic [5:0] s [7] = '{6'h00, 6'h01, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22};
        foreach (a[i]) begin
            req(FBM_OP_READ, {1'b0, a[i]}, 16'h0000);
            chk("sector", {10'h000, s[i]}, {10'h000, sec});
            chk("array", 16'hFFFF, rd);
        end
        $display("test sectors done");
    endtask
    task automatic prog_chk(input logic [20:0] a, input logic [15:0] wd, input int nw);
        wr_cnt = 0;
        req(FBM_OP_PROGRAM, a, wd);
        chk("writes", 16'(nw), 16'(wr_cnt));
        chk1("busy", 1'b1, dev_busy);
        req(FBM_OP_READ, a, 16'h0000);
        chk("status", BUSY_STATUS, rd);
        settle(1'b0);
        req(FBM_OP_READ, a, 16'h0000);
        chk("readback", wd, rd);
    endtask
    task automatic t_program();
        prog_chk(21'h00_0123, 16'hBEEF, 4);
        word_mode = 1'b0;
        prog_chk(21'h00_0247, 16'h00A5, 4);
        word_mode = 1'b1;
        req(FBM_OP_BYPASS_ENTER, 21'h00_0000, 16'h0000);
        chk1("bypass", 1'b1, bypass_active);
        prog_chk(21'h00_0300, 16'h1234, 2);
        req(FBM_OP_BYPASS_EXIT, 21'h00_0000, 16'h0000);
        chk1("bypass", 1'b0, bypass_active);
        prog_chk(21'h0F_C000, 16'h6666, 4);
        prog_chk(21'h0F_D000, 16'h5555, 4);
        $display("test program done");
    endtask
    task automatic t_erase();
        wr_cnt = 0;
        req(FBM_OP_SECTOR_ERASE, 21'h0F_D123, 16'h0000);
        chk("writes", 16'h0006, 16'(wr_cnt));
        settle(1'b0);
        req(FBM_OP_READ, 21'h0F_D000, 16'h0000);
        chk("erased", 16'hFFFF, rd);
        req(FBM_OP_READ, 21'h0F_C000, 16'h0000);
        chk("kept", 16'h6666, rd);
        req(FBM_OP_CHIP_ERASE, 21'h00_0000, 16'h0000);
        settle(1'b0);
        req(FBM_OP_READ, 21'h0F_C000, 16'h0000);
        chk("chip", 16'hFFFF, rd);
        $display("test erase done");
    endtask
    task automatic t_ident_reset();
        req(FBM_OP_IDENTIFY, 21'h00_0000, 16'h0000);
        chk1("ident", 1'b1, ident_active);
        req(FBM_OP_READ, 21'h00_0000, 16'h0000);
        chk("code", {8'h00, ID_CODE}, rd);
        req(FBM_OP_ARRAY_MODE, 21'h00_0000, 16'h0000);
        chk1("ident", 1'b0, ident_active);
        req(FBM_OP_PROGRAM, 21'h00_0400, 16'h7777);
        settle(1'b1);
        chk1("aborted", 1'b1, op_aborted);
        chk1("busy", 1'b0, dev_busy);
        prog_chk(21'h00_0400, 16'h7777, 4);
        chk1("aborted", 1'b0, op_aborted);
        req(FBM_OP_IDENTIFY, 21'h00_0000, 16'h0000);
        settle(1'b1);
        chk1("ident", 1'b0, ident_active);
        chk1("aborted", 1'b0, op_aborted);
        req(FBM_OP_READ, 21'h00_0400, 16'h0000);
        chk("array", 16'h7777, rd);
        $display("test ident and reset done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_sectors();
        t_program();
        t_erase();
        t_ident_reset();
        end_sim();
    end
    initial begin
        #400_000;
        num_errors++;
        $display("Error watchdog expected done seen timeout");
        end_sim();
    end
endmodule
